//--- common/ctmw_defs.vh
// Purpose: constants for the transceiver mode and wake-up control block
// Assumes: 50 MHz clock, 20 ns period
// Notes:   times are in ns, cycle counts derived from them
`ifndef CTMW_DEFS_VH
`define CTMW_DEFS_VH

`define CTMW_CLK_PERIOD_NS     20
`define CTMW_DOM_TIMEOUT_NS    200000
`define CTMW_DOM_TIMEOUT_CYC   (`CTMW_DOM_TIMEOUT_NS / `CTMW_CLK_PERIOD_NS)
`define CTMW_PULSE_MIN_NS      500
`define CTMW_PULSE_MIN_CYC     ((`CTMW_PULSE_MIN_NS + `CTMW_CLK_PERIOD_NS - 1) / `CTMW_CLK_PERIOD_NS)
`define CTMW_PULSE_MAX_NS      500000
`define CTMW_PULSE_MAX_CYC     (`CTMW_PULSE_MAX_NS / `CTMW_CLK_PERIOD_NS)
`define CTMW_GAP_MAX_NS        500000
`define CTMW_GAP_MAX_CYC       (`CTMW_GAP_MAX_NS / `CTMW_CLK_PERIOD_NS)
`define CTMW_WINDOW_NS         1000000
`define CTMW_WINDOW_CYC        (`CTMW_WINDOW_NS / `CTMW_CLK_PERIOD_NS)
`define CTMW_WAKE_PULSES       3
`define CTMW_SLEW_RESET        2'h0
`define CTMW_TXF_BIT           2

// chip operating modes
`define CTMW_CHIP_RESET        3'h0
`define CTMW_CHIP_NORM_REQ     3'h1
`define CTMW_CHIP_NORMAL       3'h2
`define CTMW_CHIP_STANDBY      3'h3
`define CTMW_CHIP_SLEEP        3'h4
`define CTMW_CHIP_STOP         3'h5

`endif

//--- rtl/ctmw_sync.v
// Purpose: two-flop synchroniser for a level from outside the clock domain
// Assumes: input is a slow level compared to the clock
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module ctmw_sync #(
    parameter RST_VAL = 1'b1
) (
    input  wire clk,
    input  wire rst_n,
    input  wire d_in,
    output wire q_out
);
    reg meta_ff;
    reg sync_ff;

    // reset value set so a recessive line does not look dominant at start
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= d_in;
            sync_ff <= meta_ff;
        end
    end

    assign q_out = sync_ff;
endmodule
`default_nettype wire

//--- rtl/ctmw_wake_det.v
// Purpose: pattern detector for bus wake-up
// Assumes: bus_dom is synchronised, high while the bus is dominant
// Notes:   counts are parameters so a simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
`include "ctmw_defs.vh"
module ctmw_wake_det #(
    parameter PULSE_MIN = `CTMW_PULSE_MIN_CYC,
    parameter PULSE_MAX = `CTMW_PULSE_MAX_CYC,
    parameter GAP_MAX   = `CTMW_GAP_MAX_CYC,
    parameter WIN_MAX   = `CTMW_WINDOW_CYC
) (
    input  wire clk,
    input  wire rst_n,
    input  wire enable,
    input  wire bus_dom,
    output reg  wake_pulse_ff
);
    reg        dom_d_ff;
    reg [1:0]  npulse_ff;
    reg [15:0] width_ff;
    reg [15:0] gap_ff;
    reg [16:0] win_ff;
    reg        active_ff;

    wire rise = bus_dom & ~dom_d_ff;
    wire fall = ~bus_dom & dom_d_ff;
    wire good = (width_ff >= PULSE_MIN) && (width_ff < PULSE_MAX);

    // restart on any width, gap or window violation
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dom_d_ff      <= 1'b0;
            npulse_ff     <= 2'h0;
            width_ff      <= 16'h0000;
            gap_ff        <= 16'h0000;
            win_ff        <= 17'h0_0000;
            active_ff     <= 1'b0;
            wake_pulse_ff <= 1'b0;
        end else begin
            dom_d_ff      <= bus_dom;
            wake_pulse_ff <= 1'b0;
            if (!enable) begin
                npulse_ff <= 2'h0;
                active_ff <= 1'b0;
                width_ff  <= 16'h0000;
            end else begin
                if (bus_dom && width_ff != 16'hffff)
                    width_ff <= rise ? 16'h0001 : width_ff + 16'h0001;
                if (active_ff && win_ff != 17'h1_ffff)
                    win_ff <= win_ff + 17'h0_0001;
                if (!bus_dom && gap_ff != 16'hffff)
                    gap_ff <= gap_ff + 16'h0001;
                if (active_ff && (win_ff >= WIN_MAX || (!bus_dom && gap_ff >= GAP_MAX))) begin
                    npulse_ff <= 2'h0;
                    active_ff <= 1'b0;
                end else if (fall) begin
                    gap_ff <= 16'h0000;
                    if (!good) begin
                        npulse_ff <= 2'h0;
                        active_ff <= 1'b0;
                    end else if (npulse_ff == `CTMW_WAKE_PULSES - 1) begin
                        wake_pulse_ff <= 1'b1;
                        npulse_ff     <= 2'h0;
                        active_ff     <= 1'b0;
                    end else begin
                        npulse_ff <= npulse_ff + 2'h1;
                        if (!active_ff) begin
                            active_ff <= 1'b1;
                            win_ff    <= width_ff + 17'h0_0000;
                        end
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/ctmw_can_ctrl.v
// How it works
// - transmit input pulled up to aux supply; receive low when aux supply off
// - aux supply on and normal mode: receive follows bus, low for dominant
// - four slew-rate settings 0..3 chosen by command, drive edge speed and delays
// - transmit dominant longer than 200 us switches bus driver off
// - unpowered, reset, ballast modes, sleep, stop: aux off, pins low, bus floats
// - chip and interface normal: idle bus recessive at the selected slew rate
// - interface asleep with aux supply on: pins read high, bus floats
// - low power: drivers and receiver off; wake receiver only if wake enabled at sleep entry
// - command back to normal restores recessive bus level
// - sleeping with wake disabled at sleep entry ignores bus and never wakes
// - wake in chip sleep switches main regulator on
// - wake in chip stop gives a pulse on interrupt output
// - wake in chip normal or standby sets the wake flag
// - wake flag holds until normal mode commanded and register read
// - wake needs three dominant pulses longer than 500 ns, shorter than 500 us
// - gaps under 500 us and all three pulses within 1 ms
// - after reset and normal-request: normal mode, slew rate 0
// - normal mode: high transmit recessive, low transmit dominant
// - driver re-enabled once transmit returns high after timeout
// - timeout sets latched fault bit, cleared after fault ends and register read
//
// Purpose: digital control of the bus interface: modes, slew, timeout, wake-up
// Assumes: 50 MHz clock; pins and bus receiver level come from outside the domain
// Notes:   analog levels are shown by enables, not modelled
`timescale 1ns/1ps
`default_nettype none
`include "ctmw_defs.vh"
module ctmw_can_ctrl #(
    parameter DOM_TIMEOUT = `CTMW_DOM_TIMEOUT_CYC,
    parameter PULSE_MIN   = `CTMW_PULSE_MIN_CYC,
    parameter PULSE_MAX   = `CTMW_PULSE_MAX_CYC,
    parameter GAP_MAX     = `CTMW_GAP_MAX_CYC,
    parameter WIN_MAX     = `CTMW_WINDOW_CYC
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [2:0] chip_mode,
    input  wire       ballast_ext,
    input  wire       tx_pin,
    input  wire       bus_dom_rx,
    input  wire       bus_dom_wake,
    input  wire       cmd_valid,
    input  wire       cmd_sleep,
    input  wire [1:0] cmd_slew,
    input  wire       cmd_wake_en,
    input  wire       reg_read,
    output reg        rx_pin_ff,
    output reg        tx_pullup_en_ff,
    output reg        drv_dom_ff,
    output reg        bias_recessive_ff,
    output reg        rx_enable_ff,
    output reg        wake_rx_enable_ff,
    output reg [1:0]  slew_out_ff,
    output reg        can_sleep_ff,
    output reg        aux_supply_on_ff,
    output reg        main_regulator_on_ff,
    output reg        int_pulse_ff,
    output reg        can_wake_flag_ff,
    output reg        transmit_fault_bit_ff,
    output reg        drv_off_ff
);
    wire       tx_s;
    wire       rxd_s;
    wire       wkd_s;
    wire       wake_ev;
    reg  [1:0] slew_ff;
    reg        wake_en_ff;
    reg        sleep_ff;
    reg        wake_armed_ff;
    reg [17:0] dom_cnt_ff;
    reg  [2:0] mode_d_ff;
    reg        norm_cmd_seen_ff;
    reg        aux_on;
    reg        fault_now;
    reg        nxt_drv_off;

    ctmw_sync #(.RST_VAL(1'b1)) u_sync_tx (
        .clk   (clk),
        .rst_n (rst_n),
        .d_in  (tx_pin),
        .q_out (tx_s)
    );
    ctmw_sync #(.RST_VAL(1'b0)) u_sync_rx (
        .clk   (clk),
        .rst_n (rst_n),
        .d_in  (bus_dom_rx),
        .q_out (rxd_s)
    );
    ctmw_sync #(.RST_VAL(1'b0)) u_sync_wk (
        .clk   (clk),
        .rst_n (rst_n),
        .d_in  (bus_dom_wake),
        .q_out (wkd_s)
    );

    // wake detector only runs while armed in sleep
    ctmw_wake_det #(
        .PULSE_MIN (PULSE_MIN),
        .PULSE_MAX (PULSE_MAX),
        .GAP_MAX   (GAP_MAX),
        .WIN_MAX   (WIN_MAX)
    ) u_wake (
        .clk           (clk),
        .rst_n         (rst_n),
        .enable        (sleep_ff & wake_armed_ff),
        .bus_dom       (wkd_s),
        .wake_pulse_ff (wake_ev)
    );

    // aux supply is up in normal, and in standby only when tied to main
    always @* begin
        aux_on = 1'b0;
        case (chip_mode)
            `CTMW_CHIP_NORMAL:  aux_on = 1'b1;
            `CTMW_CHIP_STANDBY: aux_on = ~ballast_ext;
            default:            aux_on = 1'b0;
        endcase
    end

    // interface mode, slew and wake arming from commands
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slew_ff       <= `CTMW_SLEW_RESET;
            sleep_ff      <= 1'b0;
            wake_en_ff    <= 1'b0;
            wake_armed_ff <= 1'b0;
            mode_d_ff     <= `CTMW_CHIP_RESET;
        end else begin
            mode_d_ff <= chip_mode;
            if (chip_mode == `CTMW_CHIP_NORM_REQ && mode_d_ff != `CTMW_CHIP_NORM_REQ) begin
                slew_ff  <= `CTMW_SLEW_RESET;
                sleep_ff <= 1'b0;
            end else if (chip_mode == `CTMW_CHIP_SLEEP || chip_mode == `CTMW_CHIP_STOP) begin
                if (!sleep_ff)
                    wake_armed_ff <= wake_en_ff;
                sleep_ff <= 1'b1;
            end else if (cmd_valid) begin
                slew_ff    <= cmd_slew;
                wake_en_ff <= cmd_wake_en;
                if (cmd_sleep && !sleep_ff)
                    wake_armed_ff <= wake_en_ff;
                sleep_ff <= cmd_sleep;
            end
        end
    end

    // dominant timeout counter; releases when transmit goes high again
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dom_cnt_ff <= 18'h0_0000;
            drv_off_ff <= 1'b0;
        end else if (tx_s || sleep_ff || !aux_on) begin
            dom_cnt_ff <= 18'h0_0000;
            drv_off_ff <= 1'b0;
        end else if (dom_cnt_ff >= DOM_TIMEOUT[17:0] - 18'h0_0001) begin
            drv_off_ff <= 1'b1;
        end else begin
            dom_cnt_ff <= dom_cnt_ff + 18'h0_0001;
        end
    end

    // fault condition present this cycle (timeout reached or still held)
    // next shut-off state lets the driver drop in the very cycle the timeout trips
    always @* begin
        fault_now   = drv_off_ff;
        nxt_drv_off = drv_off_ff;
        if (tx_s || sleep_ff || !aux_on)
            nxt_drv_off = 1'b0;
        else if (dom_cnt_ff >= DOM_TIMEOUT[17:0] - 18'h0_0001)
            nxt_drv_off = 1'b1;
    end

    // latched flags: a set in the same cycle as a clearing read wins
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            transmit_fault_bit_ff <= 1'b0;
            can_wake_flag_ff      <= 1'b0;
            norm_cmd_seen_ff      <= 1'b0;
        end else begin
            if (fault_now)
                transmit_fault_bit_ff <= 1'b1;
            else if (reg_read)
                transmit_fault_bit_ff <= 1'b0;
            if (wake_ev) begin
                can_wake_flag_ff <= 1'b1;
                norm_cmd_seen_ff <= 1'b0;
            end else if (can_wake_flag_ff) begin
                if (!sleep_ff && reg_read && norm_cmd_seen_ff) begin
                    can_wake_flag_ff <= 1'b0;
                    norm_cmd_seen_ff <= 1'b0;
                end else if (!sleep_ff) begin
                    norm_cmd_seen_ff <= 1'b1;
                end
            end
        end
    end

    // pin and driver outputs against chip and interface modes
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_pin_ff            <= 1'b0;
            tx_pullup_en_ff      <= 1'b0;
            drv_dom_ff           <= 1'b0;
            bias_recessive_ff    <= 1'b0;
            rx_enable_ff         <= 1'b0;
            wake_rx_enable_ff    <= 1'b0;
            slew_out_ff          <= `CTMW_SLEW_RESET;
            can_sleep_ff         <= 1'b0;
            aux_supply_on_ff     <= 1'b0;
            main_regulator_on_ff <= 1'b0;
            int_pulse_ff         <= 1'b0;
        end else begin
            aux_supply_on_ff  <= aux_on;
            tx_pullup_en_ff   <= aux_on;
            slew_out_ff       <= slew_ff;
            can_sleep_ff      <= sleep_ff;
            wake_rx_enable_ff <= sleep_ff & wake_armed_ff;
            int_pulse_ff      <= wake_ev && chip_mode == `CTMW_CHIP_STOP;
            main_regulator_on_ff <= chip_mode != `CTMW_CHIP_SLEEP
                                    || (wake_ev && chip_mode == `CTMW_CHIP_SLEEP);
            if (!aux_on) begin
                rx_pin_ff         <= 1'b0;
                drv_dom_ff        <= 1'b0;
                bias_recessive_ff <= 1'b0;
                rx_enable_ff      <= 1'b0;
            end else if (sleep_ff) begin
                rx_pin_ff         <= 1'b1;
                drv_dom_ff        <= 1'b0;
                bias_recessive_ff <= 1'b0;
                rx_enable_ff      <= 1'b0;
            end else begin
                rx_pin_ff         <= ~rxd_s;
                drv_dom_ff        <= ~tx_s & ~nxt_drv_off;
                bias_recessive_ff <= 1'b1;
                rx_enable_ff      <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/ctmw_can_ctrl_sva.sv
// Purpose: port-level checks for the transceiver mode and wake-up control
// Assumes: one clock domain, rst_n asynchronous and active low
// Notes:   pin windows allow for the two-stage input synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "ctmw_defs.vh"
module ctmw_can_ctrl_sva (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [2:0] chip_mode,
    input wire logic       tx_pin,
    input wire logic       cmd_valid,
    input wire logic       cmd_sleep,
    input wire logic [1:0] cmd_slew,
    input wire logic       rx_pin_ff,
    input wire logic       tx_pullup_en_ff,
    input wire logic       drv_dom_ff,
    input wire logic       bias_recessive_ff,
    input wire logic       rx_enable_ff,
    input wire logic       wake_rx_enable_ff,
    input wire logic [1:0] slew_out_ff,
    input wire logic       can_sleep_ff,
    input wire logic       aux_supply_on_ff,
    input wire logic       int_pulse_ff,
    input wire logic       can_wake_flag_ff,
    input wire logic       transmit_fault_bit_ff,
    input wire logic       drv_off_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // supply and pin relations
    property p_pullup; tx_pullup_en_ff == aux_supply_on_ff; endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up differs from aux");
    property p_rx_low; !aux_supply_on_ff && !$past(aux_supply_on_ff) |-> !rx_pin_ff; endproperty
    a_rx_low: assert property (p_rx_low) else $error("rx high with aux off");
    property p_low_pwr;
        (chip_mode == `CTMW_CHIP_SLEEP || chip_mode == `CTMW_CHIP_STOP) [*3]
            |-> !aux_supply_on_ff && !bias_recessive_ff && can_sleep_ff;
    endproperty
    a_low_pwr: assert property (p_low_pwr) else $error("low power mode not applied");
    property p_sleep_off; can_sleep_ff |-> !rx_enable_ff && !drv_dom_ff; endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("driver or rx on in sleep");

    // transmit path: a dominant edge reaches the driver within the sync latency
    property p_tx_drive;
        chip_mode == `CTMW_CHIP_NORMAL && aux_supply_on_ff && !can_sleep_ff && !drv_off_ff
            && $fell(tx_pin) |-> ##[1:4] drv_dom_ff;
    endproperty
    a_tx_drive: assert property (p_tx_drive) else $error("driver missed dominant");
    property p_to_off; drv_off_ff |-> !drv_dom_ff; endproperty
    a_to_off: assert property (p_to_off) else $error("driver on after timeout");
    property p_fault; drv_off_ff |-> ##[0:1] transmit_fault_bit_ff; endproperty
    a_fault: assert property (p_fault) else $error("fault bit not set");

    // commands and wake reporting: setting lands two cycles after the command
    property p_slew;
        cmd_valid && !cmd_sleep && chip_mode == `CTMW_CHIP_NORMAL
            |-> ##2 slew_out_ff == $past(cmd_slew, 2);
    endproperty
    a_slew: assert property (p_slew) else $error("slew not applied");
    property p_norm_req;
        $changed(chip_mode) && chip_mode == `CTMW_CHIP_NORM_REQ
            |-> ##[1:2] (slew_out_ff == 2'h0 && !can_sleep_ff);
    endproperty
    a_norm_req: assert property (p_norm_req) else $error("no default on entry");
    property p_armed; $rose(can_wake_flag_ff) |-> $past(wake_rx_enable_ff, 2); endproperty
    a_armed: assert property (p_armed) else $error("wake while not armed");
    property p_int; int_pulse_ff |-> chip_mode == `CTMW_CHIP_STOP ##1 !int_pulse_ff; endproperty
    a_int: assert property (p_int) else $error("bad interrupt pulse");

    c_wake: cover property ($rose(can_wake_flag_ff));
    c_int: cover property (int_pulse_ff);
    c_to: cover property ($rose(drv_off_ff));
endmodule
`default_nettype wire

//--- tb/ctmw_bus_model.sv
// Purpose: far side of the interface, the bus as other nodes and this driver see it
// Assumes: node_dom is driven by the bench for the other nodes
// Notes:   dominant wins over recessive, as on a real wired bus
`timescale 1ns/1ps
`default_nettype none
module ctmw_bus_model (
    input  wire logic drv_dom,
    input  wire logic node_dom,
    output wire logic bus_dom
);
    // any dominant driver pulls the bus dominant
    assign bus_dom = drv_dom | node_dom;
endmodule
`default_nettype wire

//--- tb/ctmw_can_ctrl_tb_top.sv
// Purpose: self-checking bench for the transceiver mode and wake-up control
// Assumes: short counts 20/3/40/40/100 cycles replace the real times
// Notes:   inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`default_nettype none
`include "ctmw_defs.vh"
module ctmw_can_ctrl_tb_top;
    logic       clk, rst_n, ballast_ext, tx_pin, node_dom, cmd_valid, cmd_sleep;
    logic       cmd_wake_en, reg_read;
    logic [2:0] chip_mode;
    logic [1:0] cmd_slew;
    wire        bus_dom, rx_pin_ff, tx_pullup_en_ff, drv_dom_ff, bias_recessive_ff;
    wire        rx_enable_ff, wake_rx_enable_ff, can_sleep_ff, aux_supply_on_ff;
    wire        main_regulator_on_ff, int_pulse_ff, can_wake_flag_ff;
    wire        transmit_fault_bit_ff, drv_off_ff;
    wire  [1:0] slew_out_ff;
    int         fail_count = 0, checks_done = 0, int_cnt = 0, reg_cnt = 0, n0;

    ctmw_can_ctrl #(.DOM_TIMEOUT(20), .PULSE_MIN(3), .PULSE_MAX(40), .GAP_MAX(40),
        .WIN_MAX(100)) DUT (.clk(clk), .rst_n(rst_n), .chip_mode(chip_mode),
        .ballast_ext(ballast_ext), .tx_pin(tx_pin), .bus_dom_rx(bus_dom),
        .bus_dom_wake(bus_dom), .cmd_valid(cmd_valid), .cmd_sleep(cmd_sleep),
        .cmd_slew(cmd_slew), .cmd_wake_en(cmd_wake_en), .reg_read(reg_read),
        .rx_pin_ff(rx_pin_ff), .tx_pullup_en_ff(tx_pullup_en_ff), .drv_dom_ff(drv_dom_ff),
        .bias_recessive_ff(bias_recessive_ff), .rx_enable_ff(rx_enable_ff),
        .wake_rx_enable_ff(wake_rx_enable_ff), .slew_out_ff(slew_out_ff),
        .can_sleep_ff(can_sleep_ff), .aux_supply_on_ff(aux_supply_on_ff),
        .main_regulator_on_ff(main_regulator_on_ff), .int_pulse_ff(int_pulse_ff),
        .can_wake_flag_ff(can_wake_flag_ff), .transmit_fault_bit_ff(transmit_fault_bit_ff),
        .drv_off_ff(drv_off_ff));
    ctmw_bus_model u_bus (.drv_dom(drv_dom_ff), .node_dom(node_dom), .bus_dom(bus_dom));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // wake reports are single-cycle pulses, so count them as they pass
    always @(posedge clk) begin
        if (int_pulse_ff === 1'b1) int_cnt <= int_cnt + 1;
        if (main_regulator_on_ff === 1'b1 && chip_mode == `CTMW_CHIP_SLEEP) reg_cnt <= reg_cnt + 1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic got, input logic exp, input string msg);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic cmd(input logic slp, input logic [1:0] slw, input logic wen);
        cmd_valid <= 1'b1;
        cmd_sleep <= slp;
        cmd_slew <= slw;
        cmd_wake_en <= wen;
        tick(1);
        cmd_valid <= 1'b0;
        tick(5);
    endtask
    task automatic rd;
        reg_read <= 1'b1;
        tick(1);
        reg_read <= 1'b0;
        tick(3);
    endtask
    // n dominant pulses of width w with gap g from the other nodes
    task automatic burst(input int n, input int w, input int g);
        repeat (n) begin
            node_dom <= 1'b1;
            tick(w);
            node_dom <= 1'b0;
            tick(g);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog well beyond the fewer than a thousand cycles the sequence needs
    initial begin
        #(20 * 20000);
        fail_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop;
    end

    initial begin
        // transmit starts recessive so no dominant run begins at reset release
        rst_n       <= 1'b0;
        tx_pin      <= 1'b1;
        node_dom    <= 1'b0;
        cmd_valid   <= 1'b0;
        cmd_sleep   <= 1'b0;
        cmd_wake_en <= 1'b0;
        reg_read    <= 1'b0;
        chip_mode   <= `CTMW_CHIP_RESET;
        cmd_slew    <= 2'h0;
        ballast_ext <= 1'b1;
        tick(5);
        rst_n <= 1'b1;
        chip_mode <= `CTMW_CHIP_NORM_REQ;
        tick(3);
        chip_mode <= `CTMW_CHIP_NORMAL;
        tick(6);
        chk(slew_out_ff === 2'h0 && !can_sleep_ff, 1'b1, "default mode");
        chk(bias_recessive_ff, 1'b1, "idle bias");
        chk(rx_pin_ff, 1'b1, "rx recessive");
        node_dom <= 1'b1;
        tick(6);
        chk(rx_pin_ff, 1'b0, "rx dominant");
        node_dom <= 1'b0;
        for (int i = 3; i >= 0; i--) begin
            cmd(1'b0, i[1:0], 1'b0);
            chk(slew_out_ff === i[1:0], 1'b1, "slew select");
        end
        $display("test modes and slew done");
        // a 10-cycle dominant run stays below the timeout, as a fast controller does
        tx_pin <= 1'b0;
        tick(10);
        chk(drv_dom_ff && !drv_off_ff, 1'b1, "dominant drive");
        tx_pin <= 1'b1;
        tick(6);
        chk(drv_dom_ff, 1'b0, "recessive drive");
        tx_pin <= 1'b0;
        tick(30);
        chk(drv_off_ff, 1'b1, "timeout shutdown");
        chk(drv_dom_ff, 1'b0, "driver still on");
        rd;
        chk(transmit_fault_bit_ff, 1'b1, "fault cleared during fault");
        tx_pin <= 1'b1;
        tick(6);
        chk(drv_off_ff, 1'b0, "driver not re-enabled");
        chk(transmit_fault_bit_ff, 1'b1, "fault cleared without read");
        rd;
        chk(transmit_fault_bit_ff, 1'b0, "fault not cleared");
        $display("test dominant timeout done");
        cmd(1'b1, 2'h0, 1'b0);
        chk(can_sleep_ff, 1'b1, "sleep entry");
        chk(rx_enable_ff || wake_rx_enable_ff, 1'b0, "receivers on");
        chk(rx_pin_ff && tx_pullup_en_ff && !bias_recessive_ff, 1'b1, "sleep pins");
        cmd(1'b1, 2'h0, 1'b1);
        chk(wake_rx_enable_ff, 1'b0, "late enable armed");
        burst(3, 5, 10);
        chk(can_wake_flag_ff, 1'b0, "wake while disabled");
        cmd(1'b0, 2'h0, 1'b1);
        chk(bias_recessive_ff, 1'b1, "recessive restore");
        cmd(1'b1, 2'h0, 1'b1);
        chk(wake_rx_enable_ff, 1'b1, "wake rx off");
        burst(3, 30, 35);
        tick(45);
        chk(can_wake_flag_ff, 1'b0, "window ignored");
        burst(2, 5, 10);
        tick(50);
        burst(2, 5, 10);
        chk(can_wake_flag_ff, 1'b0, "gap ignored");
        burst(1, 50, 10);
        burst(2, 5, 10);
        chk(can_wake_flag_ff, 1'b0, "no restart");
        burst(1, 5, 10);
        chk(can_wake_flag_ff, 1'b1, "no wake flag");
        rd;
        chk(can_wake_flag_ff, 1'b1, "flag cleared asleep");
        cmd(1'b0, 2'h0, 1'b1);
        chk(can_wake_flag_ff, 1'b1, "flag cleared no read");
        rd;
        chk(can_wake_flag_ff, 1'b0, "flag kept");
        $display("test wake pattern done");
        // software looks at the wake flag before it sends the chip to stop
        chk(can_wake_flag_ff, 1'b0, "flag before stop");
        chip_mode <= `CTMW_CHIP_STOP;
        tick(6);
        chk(aux_supply_on_ff || rx_pin_ff || bias_recessive_ff, 1'b0, "stop pins");
        chk(tx_pullup_en_ff, 1'b0, "pull-up in stop");
        n0 = int_cnt;
        burst(3, 5, 10);
        chk(int_cnt == n0 + 1, 1'b1, "stop interrupt");
        chip_mode <= `CTMW_CHIP_NORMAL;
        tick(4);
        chip_mode <= `CTMW_CHIP_SLEEP;
        tick(6);
        n0 = reg_cnt;
        burst(3, 5, 10);
        chk(reg_cnt == n0 + 1, 1'b1, "regulator wake");
        chip_mode <= `CTMW_CHIP_STANDBY;
        tick(6);
        chk(aux_supply_on_ff, 1'b0, "standby ballast aux");
        ballast_ext <= 1'b0;
        tick(6);
        chk(aux_supply_on_ff, 1'b1, "standby tied aux");
        $display("test chip modes done");
        report_and_stop;
    end
endmodule

bind ctmw_can_ctrl ctmw_can_ctrl_sva u_sva (.clk(clk), .rst_n(rst_n), .chip_mode(chip_mode),
    .tx_pin(tx_pin), .cmd_valid(cmd_valid), .cmd_sleep(cmd_sleep), .cmd_slew(cmd_slew),
    .rx_pin_ff(rx_pin_ff), .tx_pullup_en_ff(tx_pullup_en_ff), .drv_dom_ff(drv_dom_ff),
    .bias_recessive_ff(bias_recessive_ff), .rx_enable_ff(rx_enable_ff),
    .wake_rx_enable_ff(wake_rx_enable_ff), .slew_out_ff(slew_out_ff),
    .can_sleep_ff(can_sleep_ff), .aux_supply_on_ff(aux_supply_on_ff),
    .int_pulse_ff(int_pulse_ff), .can_wake_flag_ff(can_wake_flag_ff),
    .transmit_fault_bit_ff(transmit_fault_bit_ff), .drv_off_ff(drv_off_ff));
`default_nettype wire
